// ==== rtl/mpmtx_regs.svh ====
// register map, field positions and timing counts of the multipoint tx timing core
// assumes inclusion by bare name from the package and the testbench
`ifndef MPMTX_REGS_SVH
`define MPMTX_REGS_SVH
`define MPMTX_CLK_PERIOD_PS 25000
`define MPMTX_QUANTUM_NS 16
`define MPMTX_QUANTUM_OCTETS 2
`define MPMTX_ONU_DRIFT_LIMIT 8
`define MPMTX_OLT_DRIFT_LIMIT 12
`define MPMTX_CTRL_TYPE 16'h8808
`define MPMTX_TAIL_RESERVE 29
`define MPMTX_FEC_BASE 13
`define MPMTX_FEC_BLOCK 239
`define MPMTX_FEC_PER_BLOCK 8
`define MPMTX_IPG_QUANTA 6
// register byte offsets
`define MPMTX_OFF_CTRL 12'h000
`define MPMTX_OFF_STATUS 12'h004
`define MPMTX_OFF_TIME 12'h008
`define MPMTX_OFF_GRANT_END 12'h00C
`define MPMTX_OFF_OPCODES 12'h010
`define MPMTX_OFF_LOOP_DELAY 12'h014
// control field positions
`define MPMTX_CTRL_ONU_BIT 0
`define MPMTX_CTRL_FEC_BIT 1
`define MPMTX_CTRL_TXOPEN_BIT 2
`define MPMTX_CTRL_BEGIN_BIT 3
// status field positions
`define MPMTX_ST_DRIFT_BIT 0
`define MPMTX_ST_BUSY_BIT 1
`endif

// ==== rtl/mpmtx_pkg.sv ====
// types shared by the multipoint tx timing core
// assumes mpmtx_regs.svh holds the numeric constants
package mpmtx_pkg;
`include "mpmtx_regs.svh"
    typedef enum logic [1:0] {
        MX_IDLE,
        MX_DELAY,
        MX_SEND
    } mpmtx_mux_st_t;
endpackage

// ==== rtl/mpmtx_tick.sv ====
// quantum tick generator: enable high every clock cycle (every 25 ns), not every 16 ns
// assumes a 40 MHz clk; 16 ns is 16/25 of a cycle, so the accumulator passes the quantum every cycle and ticks each cycle
`timescale 1ns/1ps
module mpmtx_tick
    import mpmtx_pkg::*;
#(
    parameter int unsigned PERIOD_PS = `MPMTX_CLK_PERIOD_PS,
    parameter int unsigned QUANT_PS = `MPMTX_QUANTUM_NS * 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // quantum enable out
    output logic tick
);
    initial begin
        if (PERIOD_PS > 2 * QUANT_PS || QUANT_PS == 0) begin
            $error("mpmtx_tick: clock too slow for one tick per cycle");
        end
    end
    typedef struct packed {
        logic [31:0] acc;
        logic tick;
    } mpmtx_tick_state_t;
    mpmtx_tick_state_t state_reg, state_next;
    always_comb begin
        logic [31:0] sum;
        sum = state_reg.acc + PERIOD_PS;
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (sum >= QUANT_PS) begin
            state_next.acc = sum - QUANT_PS;
            state_next.tick = 1'b1;
        end else begin
            state_next.acc = sum;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign tick = state_reg.tick;
endmodule // mpmtx_tick

// ==== rtl/mpmtx_fec_cost.sv ====
// parity time cost: 13 + 8 * ceil(len / 239) quanta, combinational
// assumes frame length in octets, preamble through fcs
`timescale 1ns/1ps
module mpmtx_fec_cost
    import mpmtx_pkg::*;
(
    // frame length in
    input wire logic [15:0] frame_len,
    // cost out
    output logic [15:0] parity_time_cost
);
    logic [15:0] blocks;
    always_comb begin
        blocks = 16'((32'(frame_len) + `MPMTX_FEC_BLOCK - 1) / `MPMTX_FEC_BLOCK);
        parity_time_cost = 16'(`MPMTX_FEC_BASE + 32'(blocks) * `MPMTX_FEC_PER_BLOCK);
    end
endmodule // mpmtx_fec_cost

// ==== rtl/mpmtx_core.sv ====
// multipoint mac control tx timing core: quantum timer, drift checks, instance
// arbitration, control-frame priority multiplexer with initiate delay and grant fit
// assumes one 40 MHz clk, APB slave for registers, receive side hands parsed pdus
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module mpmtx_core
    import mpmtx_pkg::*;
#(
    parameter int unsigned N_INST = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // received control pdu from the mac side
    input wire logic rx_valid,
    input wire logic [15:0] rx_length_type,
    input wire logic [15:0] rx_opcode,
    input wire logic [31:0] rx_timestamp,
    output logic opcode_handler_start,
    output logic [15:0] opcode_handler_code,
    // per instance transmit requests
    input wire logic [N_INST-1:0] instance_has_frame,
    input wire logic [N_INST-1:0] inst_is_ctrl,
    input wire logic [N_INST-1:0] inst_frame_done,
    input wire logic [N_INST*16-1:0] inst_frame_len,
    input wire logic [N_INST*16-1:0] inst_opcode,
    output logic [N_INST-1:0] instance_tx_grant,
    output logic [N_INST-1:0] instance_sending,
    output logic any_frame_waiting,
    // transmit stamp to mac
    output logic tx_first_octet,
    output logic [15:0] tx_length_type,
    output logic [31:0] tx_timestamp
);
    initial begin
        if (N_INST < 1 || N_INST > 16) begin
            $error("mpmtx_core: N_INST must be 1..16");
        end
    end
    localparam int unsigned IW = (N_INST > 1) ? $clog2(N_INST) : 1;

    typedef struct packed {
        logic onu_mode;
        logic parity_coding_on;
        logic onu_tx_open;
        logic [31:0] quantum_counter;
        logic [31:0] grant_end_time;
        logic [15:0] stored_loop_delay;
        logic [15:0] fresh_loop_delay;
        logic [15:0] opcode_rx;
        logic [15:0] opcode_tx;
        logic drift_error_flag;
        logic handler_start;
        mpmtx_mux_st_t mux_st;
        logic [15:0] wait_cnt;
        logic [IW-1:0] sel;
        logic first_octet;
        logic [15:0] tx_lt;
        logic [31:0] tx_ts;
        logic [31:0] prdata;
    } mpmtx_core_state_t;
    mpmtx_core_state_t state_reg, state_next;

    logic tick;
    logic [15:0] parity_time_cost;
    logic [15:0] sel_len;
    logic [15:0] next_packet_duration;
    logic fits;
    logic pick_valid;
    logic [IW-1:0] pick_idx;
    logic begin_flag;

    // quanta tick: one per cycle of the 40 MHz clock, a 40 MHz rate
    mpmtx_tick u_tick (
        .clk(clk),
        .srst(srst),
        .tick(tick)
    );

    assign sel_len = inst_frame_len[state_reg.sel*16 +: 16];

    mpmtx_fec_cost u_fec (
        .frame_len(16'(sel_len + `MPMTX_TAIL_RESERVE)),
        .parity_time_cost(parity_time_cost)
    );

    // length plus tail reserve in quanta (two octets per quantum), plus parity cost
    always_comb begin
        logic [16:0] oct;
        oct = 17'(sel_len) + 17'(`MPMTX_TAIL_RESERVE);
        next_packet_duration = 16'((oct + 17'(`MPMTX_QUANTUM_OCTETS - 1))
            / 17'(`MPMTX_QUANTUM_OCTETS));
        if (state_reg.parity_coding_on) begin
            next_packet_duration = next_packet_duration + parity_time_cost;
        end
    end
    // wrap-aware fit: remaining = grant_end - now, signed
    always_comb begin
        logic [31:0] remain;
        remain = state_reg.grant_end_time - state_reg.quantum_counter;
        fits = !remain[31] && (remain >= 32'(next_packet_duration));
    end

    // picker: lowest control-frame instance first, else lowest pending
    always_comb begin
        pick_valid = 1'b0;
        pick_idx = '0;
        for (int i = N_INST - 1; i >= 0; i--) begin
            if (instance_has_frame[i]) begin
                pick_valid = 1'b1;
                pick_idx = IW'(i);
            end
        end
        for (int i = N_INST - 1; i >= 0; i--) begin
            if (instance_has_frame[i] && inst_is_ctrl[i]) begin
                pick_idx = IW'(i);
            end
        end
    end
    assign any_frame_waiting = |instance_has_frame;

    assign begin_flag = psel && penable && pwrite && paddr == `MPMTX_OFF_CTRL
        && pwdata[`MPMTX_CTRL_BEGIN_BIT];

    always_comb begin
        logic [31:0] diff;
        logic [15:0] dd;
        logic [15:0] delay;
        logic drift_evt;
        diff = '0;
        dd = '0;
        delay = '0;
        drift_evt = 1'b0;
        state_next = state_reg;
        state_next.handler_start = 1'b0;
        state_next.first_octet = 1'b0;
        if (tick) begin
            state_next.quantum_counter = state_reg.quantum_counter + 32'd1;
        end
        // receive path, never stalls on the handler
        if (rx_valid && rx_length_type == `MPMTX_CTRL_TYPE) begin
            state_next.opcode_rx = rx_opcode;
            state_next.handler_start = 1'b1;
            if (state_reg.onu_mode) begin
                diff = rx_timestamp - state_reg.quantum_counter;
                if (diff[31]) begin
                    diff = -diff;
                end
                if (diff > `MPMTX_ONU_DRIFT_LIMIT) begin
                    state_next.drift_error_flag = 1'b1;
                    drift_evt = 1'b1;
                end
                state_next.quantum_counter = rx_timestamp;
            end else begin
                diff = state_reg.quantum_counter - rx_timestamp;
                state_next.fresh_loop_delay = diff[15:0];
                state_next.stored_loop_delay = diff[15:0];
                dd = diff[15:0] - state_reg.stored_loop_delay;
                if (dd[15]) begin
                    dd = -dd;
                end
                if (dd > `MPMTX_OLT_DRIFT_LIMIT) begin
                    state_next.drift_error_flag = 1'b1;
                    drift_evt = 1'b1;
                end
            end
        end
        // multiplexer
        delay = 16'(`MPMTX_IPG_QUANTA);
        if (state_reg.parity_coding_on) begin
            delay = delay + parity_time_cost;
        end
        case (state_reg.mux_st)
            MX_IDLE: begin
                if (pick_valid) begin
                    state_next.sel = pick_idx;
                    state_next.wait_cnt = '0;
                    state_next.mux_st = MX_DELAY;
                end
            end
            MX_DELAY: begin
                if (tick) begin
                    state_next.wait_cnt = state_reg.wait_cnt + 16'd1;
                end
                if (!instance_has_frame[state_reg.sel]) begin
                    state_next.mux_st = MX_IDLE;
                end else if (state_reg.wait_cnt >= delay) begin
                    if (state_reg.onu_mode && (!state_reg.onu_tx_open || !fits)) begin
                        state_next.mux_st = MX_DELAY;
                    end else begin
                        state_next.mux_st = MX_SEND;
                        state_next.first_octet = 1'b1;
                        state_next.tx_ts = state_reg.quantum_counter;
                        state_next.tx_lt = inst_is_ctrl[state_reg.sel]
                            ? `MPMTX_CTRL_TYPE : 16'h0000;
                        if (inst_is_ctrl[state_reg.sel]) begin
                            state_next.opcode_tx = inst_opcode[state_reg.sel*16 +: 16];
                        end
                    end
                end
            end
            MX_SEND: begin
                if (inst_frame_done[state_reg.sel]) begin
                    state_next.mux_st = MX_IDLE;
                end
            end
            default: state_next.mux_st = MX_IDLE;
        endcase
        // apb
        if (psel && !penable && !pwrite) begin
            if (paddr == `MPMTX_OFF_CTRL) begin
                state_next.prdata = {28'h000_0000, 1'b0, state_reg.onu_tx_open,
                    state_reg.parity_coding_on, state_reg.onu_mode};
            end else if (paddr == `MPMTX_OFF_STATUS) begin
                state_next.prdata = {30'h0000_0000, state_reg.mux_st != MX_IDLE,
                    state_reg.drift_error_flag};
            end else if (paddr == `MPMTX_OFF_TIME) begin
                state_next.prdata = state_reg.quantum_counter;
            end else if (paddr == `MPMTX_OFF_GRANT_END) begin
                state_next.prdata = state_reg.grant_end_time;
            end else if (paddr == `MPMTX_OFF_OPCODES) begin
                state_next.prdata = {state_reg.opcode_tx, state_reg.opcode_rx};
            end else if (paddr == `MPMTX_OFF_LOOP_DELAY) begin
                state_next.prdata = {state_reg.stored_loop_delay, state_reg.fresh_loop_delay};
            end else begin
                state_next.prdata = 32'h0000_0000;
            end
        end
        if (psel && penable && pwrite) begin
            if (paddr == `MPMTX_OFF_CTRL) begin
                state_next.onu_mode = pwdata[`MPMTX_CTRL_ONU_BIT];
                state_next.parity_coding_on = pwdata[`MPMTX_CTRL_FEC_BIT];
                state_next.onu_tx_open = pwdata[`MPMTX_CTRL_TXOPEN_BIT];
            end else if (paddr == `MPMTX_OFF_STATUS) begin
                // write one clears; a drift event in the same cycle wins
                if (pwdata[`MPMTX_ST_DRIFT_BIT] && !drift_evt) begin
                    state_next.drift_error_flag = 1'b0;
                end
            end else if (paddr == `MPMTX_OFF_TIME) begin
                state_next.quantum_counter = pwdata;
            end else if (paddr == `MPMTX_OFF_GRANT_END) begin
                state_next.grant_end_time = pwdata;
            end
        end
        if (begin_flag) begin
            state_next.mux_st = MX_IDLE;
            state_next.wait_cnt = '0;
            state_next.drift_error_flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // single grant: one-hot of the selected instance in send
    always_comb begin
        instance_tx_grant = '0;
        instance_sending = '0;
        if (state_reg.mux_st == MX_SEND) begin
            instance_tx_grant[state_reg.sel] = 1'b1;
            instance_sending[state_reg.sel] = 1'b1;
        end
    end

    assign opcode_handler_start = state_reg.handler_start;
    assign opcode_handler_code = state_reg.opcode_rx;
    assign tx_first_octet = state_reg.first_octet;
    assign tx_length_type = state_reg.tx_lt;
    assign tx_timestamp = state_reg.tx_ts;
    assign prdata = state_reg.prdata;
    assign pready = psel && penable;
    assign pslverr = 1'b0;

    a_grant_onehot: assert property (@(posedge clk) disable iff (srst)
        $onehot0(instance_tx_grant)) else $error("more than one grant");
    a_waiting_or: assert property (@(posedge clk) disable iff (srst)
        any_frame_waiting == (instance_has_frame != '0)) else $error("waiting wrong");
    a_pending_start: assert property (@(posedge clk) disable iff (srst)
        (state_reg.mux_st == MX_IDLE && any_frame_waiting && !begin_flag)
        |=> state_reg.mux_st == MX_DELAY) else $error("pending frame not picked up");
    a_onu_reload: assert property (@(posedge clk) disable iff (srst)
        (rx_valid && rx_length_type == 16'h8808 && state_reg.onu_mode && !begin_flag
        && !(psel && penable && pwrite))
        |=> state_reg.quantum_counter == $past(rx_timestamp)) else $error("no reload");
    a_handler_strobe: assert property (@(posedge clk) disable iff (srst)
        (rx_valid && rx_length_type == 16'h8808) |=> opcode_handler_start)
        else $error("handler not started");
    a_send_open: assert property (@(posedge clk) disable iff (srst)
        (tx_first_octet && state_reg.onu_mode) |-> $past(state_reg.onu_tx_open))
        else $error("sent while closed");
    sequence s_send_start;
        state_reg.mux_st == MX_DELAY ##1 state_reg.mux_st == MX_SEND;
    endsequence
    a_ctrl_type: assert property (@(posedge clk) disable iff (srst)
        s_send_start |-> (tx_length_type == 16'h8808) == inst_is_ctrl[state_reg.sel])
        else $error("type mark wrong");
    a_stamp_time: assert property (@(posedge clk) disable iff (srst)
        tx_first_octet |-> tx_timestamp == $past(state_reg.quantum_counter))
        else $error("stamp wrong");
    a_begin_idle: assert property (@(posedge clk) disable iff (srst)
        begin_flag |=> state_reg.mux_st == MX_IDLE) else $error("begin ignored");
endmodule // mpmtx_core

// ==== bench/mpmtx_inst_model.sv ====
// far-side model: per-instance frame sources standing behind the tx arbiter
// assumes one clock; the bench posts frames, the model ends each granted frame
`timescale 1ns/1ps
module mpmtx_inst_model
    import mpmtx_pkg::*;
#(
    parameter int unsigned N_INST = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bench requests and frame length in cycles
    input wire logic [N_INST-1:0] req,
    input wire logic [N_INST-1:0] req_ctrl,
    input wire logic [7:0] hold,
    // arbiter side
    input wire logic [N_INST-1:0] instance_tx_grant,
    output logic [N_INST-1:0] instance_has_frame,
    output logic [N_INST-1:0] inst_is_ctrl,
    output logic [N_INST-1:0] inst_frame_done
);
    logic [7:0] cnt;
    logic [N_INST-1:0] nh;
    always @(posedge clk) begin
        nh = instance_has_frame | req;
        inst_frame_done <= '0;
        if (srst) begin
            instance_has_frame <= '0;
            inst_is_ctrl <= '0;
            cnt <= '0;
        end else begin
            inst_is_ctrl <= (inst_is_ctrl & ~req) | (req & req_ctrl);
            // a frame stays pending until the granted transfer ends
            if (|(instance_tx_grant & instance_has_frame)) begin
                if (cnt == hold) begin
                    inst_frame_done <= instance_tx_grant;
                    nh = nh & ~instance_tx_grant;
                    cnt <= '0;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
            instance_has_frame <= nh;
        end
    end
endmodule // mpmtx_inst_model

// ==== bench/tb_multipoint_mac_control_tx_timing.sv ====
// self-checking bench of the multipoint tx timing core
// assumes the package, the core and the instance model are compiled first
`timescale 1ns/1ps
`include "mpmtx_regs.svh"
module tb_multipoint_mac_control_tx_timing
    import mpmtx_pkg::*;
;
    localparam int N = 4;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, rx_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rx_timestamp, tx_timestamp, base_ts, base_cyc, cyc, hs_cnt;
    logic [15:0] rx_length_type, rx_opcode, opcode_handler_code, tx_length_type;
    logic opcode_handler_start, any_frame_waiting, tx_first_octet;
    logic [N-1:0] has, is_ctrl, done, grant, sending, req, req_ctrl;
    logic [7:0] hold;
    logic [31:0] r, r2;
    int failures, checks_done, n, n_plain;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (srst) begin
            cyc <= '0;
            hs_cnt <= '0;
        end else begin
            cyc <= cyc + 1;
            if (opcode_handler_start === 1'b1) begin
                hs_cnt <= hs_cnt + 1;
            end
        end
    end

    mpmtx_core #(.N_INST(N)) i_mpmtx_core (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_length_type(rx_length_type), .rx_opcode(rx_opcode), .rx_timestamp(rx_timestamp),
        .opcode_handler_start(opcode_handler_start),
        .opcode_handler_code(opcode_handler_code), .instance_has_frame(has),
        .inst_is_ctrl(is_ctrl), .inst_frame_done(done), .inst_frame_len({N{16'h0064}}),
        .inst_opcode({N{16'h0003}}), .instance_tx_grant(grant), .instance_sending(sending),
        .any_frame_waiting(any_frame_waiting), .tx_first_octet(tx_first_octet),
        .tx_length_type(tx_length_type), .tx_timestamp(tx_timestamp));
    mpmtx_inst_model #(.N_INST(N)) i_mpmtx_inst_model (.clk(clk), .srst(srst), .req(req),
        .req_ctrl(req_ctrl), .hold(hold), .instance_tx_grant(grant),
        .instance_has_frame(has), .inst_is_ctrl(is_ctrl), .inst_frame_done(done));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // control frames also rebase the expected local time
    task automatic send_rx(input logic [15:0] t, input logic [15:0] op, input logic [31:0] ts);
        rx_valid <= 1'b1;
        rx_length_type <= t;
        rx_opcode <= op;
        rx_timestamp <= ts;
        @(posedge clk);
        if (t == `MPMTX_CTRL_TYPE) begin
            base_ts = ts;
            base_cyc = cyc;
        end
        rx_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [31:0] ts_now();
        return base_ts + (cyc - base_cyc);
    endfunction
    task automatic post(input logic [N-1:0] m, input logic [N-1:0] c);
        req <= m;
        req_ctrl <= c;
        @(posedge clk);
        req <= '0;
    endtask
    task automatic wait_first(input int lim);
        n = 0;
        while (tx_first_octet !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic t_reset;
        apb(0, `MPMTX_OFF_CTRL, 0);
        check("ctrl_rst", r, 32'h0000_0000);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("status_rst", r, 32'h0000_0000);
        apb(0, 12'h020, 0);
        check("unmapped", r, 32'h0000_0000);
        check("pslverr", pslverr, 0);
        apb(1, `MPMTX_OFF_TIME, 32'hFFFF_FFFF);
        apb(0, `MPMTX_OFF_TIME, 0);
        check("time_wrap", r < 8, 1);
        apb(0, `MPMTX_OFF_TIME, 0);
        r2 = r;
        apb(0, `MPMTX_OFF_TIME, 0);
        check("time_rate", r - r2, 3);
        $display("t_reset done");
    endtask
    task automatic t_drift;
        apb(1, `MPMTX_OFF_CTRL, 32'h0000_0001);
        send_rx(`MPMTX_CTRL_TYPE, 16'h0003, 32'h1000_0000);
        check("handler_cnt", hs_cnt, 1);
        check("handler_op", opcode_handler_code, 16'h0003);
        send_rx(16'h0800, 16'h0002, 32'h0000_0000);
        check("data_no_handler", hs_cnt, 1);
        apb(1, `MPMTX_OFF_STATUS, 32'h0000_0001);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("drift_w1c", r[0], 0);
        send_rx(`MPMTX_CTRL_TYPE, 16'h0004, ts_now() + 2);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("drift_small", r[0], 0);
        send_rx(`MPMTX_CTRL_TYPE, 16'h0004, ts_now() + 30);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("drift_big", r[0], 1);
        apb(1, `MPMTX_OFF_CTRL, 32'h0000_0009);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("begin_clears", r[0], 0);
        $display("t_drift done");
    endtask
    task automatic t_onu_tx;
        apb(1, `MPMTX_OFF_GRANT_END, ts_now() + 1000);
        post(4'b0001, 4'b0000);
        wait_first(40);
        check("closed_holds", n, 40);
        apb(1, `MPMTX_OFF_CTRL, 32'h0000_0005);
        wait_first(60);
        check("open_sends", n < 60, 1);
        check("stamp", tx_timestamp - ts_now() + 3 < 7, 1);
        repeat (12) @(posedge clk);
        apb(1, `MPMTX_OFF_GRANT_END, ts_now() + 20);
        post(4'b0001, 4'b0000);
        wait_first(60);
        check("no_fit", n, 60);
        apb(1, `MPMTX_OFF_CTRL, 32'h0000_0000);
        wait_first(60);
        check("olt_sends", n < 60, 1);
        repeat (12) @(posedge clk);
        $display("t_onu_tx done");
    endtask
    task automatic t_olt_tx;
        post(4'b0110, 4'b0100);
        wait_first(60);
        n_plain = n;
        check("ctrl_first", grant, 4'b0100);
        check("sending", sending, grant);
        check("ctrl_type", tx_length_type, `MPMTX_CTRL_TYPE);
        check("waiting", any_frame_waiting, 1);
        check("init_delay", n >= `MPMTX_IPG_QUANTA, 1);
        @(posedge clk);
        wait_first(60);
        check("second", grant, 4'b0010);
        check("data_type", tx_length_type, 16'h0000);
        repeat (12) @(posedge clk);
        check("idle_wait", any_frame_waiting, 0);
        check("idle_grant", grant, 4'b0000);
        $display("t_olt_tx done");
    endtask
    task automatic t_fec;
        apb(1, `MPMTX_OFF_CTRL, 32'h0000_0002);
        post(4'b1000, 4'b0000);
        wait_first(80);
        // 100 + 29 octets fit one block: 13 + 8 quanta of parity time
        check("fec_extra", n - n_plain, 21);
        check("fec_grant", grant, 4'b1000);
        repeat (12) @(posedge clk);
        $display("t_fec done");
    endtask
    // olt mode: counter set to a known value, loop delay = 0x1001 - timestamp
    task automatic t_olt_rx;
        apb(1, `MPMTX_OFF_TIME, 32'h0000_1000);
        send_rx(`MPMTX_CTRL_TYPE, 16'h0005, 32'h0000_0FE1);
        apb(1, `MPMTX_OFF_STATUS, 32'h0000_0001);
        apb(0, `MPMTX_OFF_LOOP_DELAY, 0);
        check("loop_delay", r, 32'h0020_0020);
        apb(0, `MPMTX_OFF_OPCODES, 0);
        check("opcodes", r, 32'h0003_0005);
        apb(1, `MPMTX_OFF_TIME, 32'h0000_1000);
        send_rx(`MPMTX_CTRL_TYPE, 16'h0005, 32'h0000_0FD9);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("olt_small", r[0], 0);
        apb(1, `MPMTX_OFF_TIME, 32'h0000_1000);
        send_rx(`MPMTX_CTRL_TYPE, 16'h0005, 32'h0000_0FC0);
        apb(0, `MPMTX_OFF_STATUS, 0);
        check("olt_big", r[0], 1);
        $display("t_olt_rx done");
    endtask

    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        conclude;
    end
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        rx_valid = 1'b0;
        rx_length_type = '0;
        rx_opcode = '0;
        rx_timestamp = '0;
        req = '0;
        req_ctrl = '0;
        hold = 8'h04;
        base_ts = '0;
        base_cyc = '0;
        failures = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_drift;
        t_onu_tx;
        t_olt_tx;
        t_fec;
        t_olt_rx;
        conclude;
    end
endmodule // tb_multipoint_mac_control_tx_timing
